// ==== bench/hcor_plc_model.sv ====
// host side model writing and reading the command registers
`default_nettype none
module hcor_plc_model (
  input  wire logic        clk_sys,
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_valid,
  output var  logic        wr_en = 1'b0,
  output var  logic        rd_en = 1'b0,
  output var  logic [7:0]  addr = 8'h00,
  output var  logic [15:0] wr_data = 16'h0000
);
  timeunit 1ns;
  timeprecision 1ns;
  // released lines scrambled so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    #1;
    wr_en = 1'b1;
    addr = a;
    wr_data = d;
    @(posedge clk_sys);
    #1;
    wr_en = 1'b0;
    addr = ~a;
    wr_data = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic v);
    @(posedge clk_sys);
    #1;
    rd_en = 1'b1;
    addr = a;
    @(posedge clk_sys);
    #1;
    rd_en = 1'b0;
    addr = ~a;
    v = rd_valid;
    d = rd_data;
  endtask
endmodule // hcor_plc_model
`default_nettype wire

// ==== bench/hcor_props.sv ====
// assertions for the host command register bank
`default_nettype none
`include "hcor_defines.vh"
module hcor_props (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        wr_en,
  input wire logic [7:0]  addr,
  input wire logic [15:0] wr_data,
  input wire logic        aux_left_usage_none,
  input wire logic        aux_left_out,
  input wire logic        aux_left_oe,
  input wire logic        fault_left_set,
  input wire logic        fault_left,
  input wire logic        motor_reset_pulse,
  input wire logic        stop_group_stopped,
  input wire logic        upstream_jam_clear_pulse,
  input wire logic        downstream_jam_clear_pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire logic stop_wr = wr_en && addr == `HCOR_OFF_STOP_CMD;
  chk_stop_enter: assert property (stop_wr && wr_data == 16'h0001 |=> stop_group_stopped)
    else $error("stop group not entered");
  chk_stop_leave: assert property (stop_wr && wr_data == 16'h0002 |=> !stop_group_stopped)
    else $error("stop group not cleared");
  chk_up_jam_cause: assert property (upstream_jam_clear_pulse |-> $past(wr_en)
    && $past(addr) == `HCOR_OFF_UP_JAM && $past(wr_data) != 16'h0000) else $error("stray up pulse");
  chk_dn_jam_cause: assert property (downstream_jam_clear_pulse |-> $past(wr_en)
    && $past(addr) == `HCOR_OFF_DN_JAM && $past(wr_data) != 16'h0000) else $error("stray dn pulse");
  chk_level_needs_dir: assert property (aux_left_out |-> aux_left_oe)
    else $error("level driven without output direction");
  // usage may pass a flop, so allow settling
  chk_usage_blocks_pin: assert property (!aux_left_usage_none [*3] |-> !aux_left_oe)
    else $error("pin driven while usage not none");
  chk_fault_latched: assert property (fault_left && !motor_reset_pulse |=> fault_left)
    else $error("fault dropped without reset");
  chk_fault_reset: assert property (motor_reset_pulse && !fault_left_set |=> !fault_left)
    else $error("fault kept after reset");
  chk_up_jam_single: assert property (upstream_jam_clear_pulse |=> !upstream_jam_clear_pulse)
    else $error("up jam pulse longer than one cycle");
  chk_dn_jam_single: assert property (downstream_jam_clear_pulse |=> !downstream_jam_clear_pulse)
    else $error("dn jam pulse longer than one cycle");
  chk_reset_single: assert property (motor_reset_pulse |=> !motor_reset_pulse)
    else $error("motor reset pulse longer than one cycle");
  cover property (motor_reset_pulse);
  cover property (upstream_jam_clear_pulse);
  cover property (stop_group_stopped);
endmodule // hcor_props
bind hcor_host_command_output_registers hcor_props chk_u (.clk_sys, .rst, .wr_en, .addr,
  .wr_data, .aux_left_usage_none, .aux_left_out, .aux_left_oe, .fault_left_set, .fault_left,
  .motor_reset_pulse, .stop_group_stopped, .upstream_jam_clear_pulse, .downstream_jam_clear_pulse);
`default_nettype wire

// ==== bench/tb.sv ====
// self-checking bench for the host command registers
`default_nettype none
`include "hcor_defines.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, rst = 1'b1, aux_left_usage_none = 1'b1, aux_right_usage_none = 1'b1;
  logic fault_left_set = 1'b0, fault_right_set = 1'b0, wr_en, rd_en, rd_valid, v;
  logic aux_left_out, aux_left_oe, aux_right_out, aux_right_oe, fault_left, fault_right;
  logic motor_reset_pulse, stop_group_stopped, upstream_jam_clear_pulse, downstream_jam_clear_pulse;
  logic [7:0]  addr, ja[2] = '{`HCOR_OFF_UP_JAM, `HCOR_OFF_DN_JAM};
  logic [15:0] wr_data, rd_data, d, induct_fwd_word1, induct_fwd_word2, induct_rev_word1;
  logic [15:0] induct_rev_word2, sc[5] = '{1, 0, 3, 2, 0}, se[5] = '{1, 1, 1, 0, 0};
  int errors = 0, comparisons = 0, n_up = 0, n_dn = 0, n_mr = 0;
  hcor_host_command_output_registers #(.RESET_HOLD_CYC(20)) dut_u (.clk_sys, .rst, .wr_en,
    .rd_en, .addr, .wr_data, .rd_data, .rd_valid, .aux_left_usage_none, .aux_right_usage_none,
    .aux_left_in(1'b1), .aux_right_in(1'b0), .aux_left_out, .aux_left_oe, .aux_right_out,
    .aux_right_oe, .induct_fwd_word1, .induct_fwd_word2, .induct_rev_word1, .induct_rev_word2,
    .fault_left_set, .fault_right_set, .fault_left, .fault_right, .motor_reset_pulse,
    .stop_group_stopped, .upstream_jam_clear_pulse, .downstream_jam_clear_pulse);
  hcor_plc_model plc_u (.clk_sys, .rd_data, .rd_valid, .wr_en, .rd_en, .addr, .wr_data);
  initial forever #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    n_up <= n_up + int'(upstream_jam_clear_pulse === 1'b1);
    n_dn <= n_dn + int'(downstream_jam_clear_pulse === 1'b1);
    n_mr <= n_mr + int'(motor_reset_pulse === 1'b1);
  end
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [15:0] e, input string n);
    plc_u.rd(a, d, v);
    chk("rd_valid", 16'(v), 16'h0001);
    chk(n, d, e);
  endtask
  task automatic idle(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic aux(input logic [15:0] w, input logic [15:0] e);
    plc_u.wr(`HCOR_OFF_AUX_CTRL, w);
    idle(2);
    chk("aux pins", 16'({aux_left_oe, aux_right_oe, aux_left_out, aux_right_out}), e);
  endtask
  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    errors++;
    results();
  end
  initial begin
    idle(2);
    rst = 1'b0;
    plc_u.wr(`HCOR_OFF_FWD_W1, 16'hA5C3);
    plc_u.wr(`HCOR_OFF_FWD_W2, 16'h0001);
    plc_u.wr(`HCOR_OFF_REV_W1, 16'hFFFF);
    plc_u.wr(`HCOR_OFF_REV_W2, 16'h8000);
    idle(2);
    chk("fwd word1", induct_fwd_word1, 16'hA5C3);
    chk("fwd word2", induct_fwd_word2, 16'h0001);
    chk("rev word1", induct_rev_word1, 16'hFFFF);
    chk("rev word2", induct_rev_word2, 16'h8000);
    rdchk(`HCOR_OFF_REV_W2, 16'h8000, "rev2 read");
    rdchk(`HCOR_OFF_FWD_W1, 16'hA5C3, "fwd1 read");
    rdchk(8'h00, 16'h0000, "unmapped read");
    $display("test tracking done");
    aux(16'hFFFF, 16'h000F);
    rdchk(`HCOR_OFF_AUX_CTRL, 16'h3301, "aux read");
    aux(16'h0300, 16'h000C);
    aux(16'h3000, 16'h0000);
    aux_left_usage_none = 1'b0;
    aux(16'h3300, 16'h0005);
    aux_left_usage_none = 1'b1;
    $display("test aux done");
    foreach (sc[i]) begin
      plc_u.wr(`HCOR_OFF_STOP_CMD, sc[i]);
      chk("stopped", 16'(stop_group_stopped), se[i]);
    end
    $display("test stop done");
    foreach (ja[i]) begin
      plc_u.wr(ja[i], 16'h0001);
      plc_u.wr(ja[i], 16'h0001);
      plc_u.wr(ja[i], 16'h0000);
      plc_u.wr(ja[i], 16'h8000);
    end
    idle(2);
    chk("up jam pulses", 16'(n_up), 16'h0002);
    chk("dn jam pulses", 16'(n_dn), 16'h0002);
    $display("test jam done");
    fault_left_set = 1'b1;
    fault_right_set = 1'b1;
    idle(1);
    fault_left_set = 1'b0;
    fault_right_set = 1'b0;
    plc_u.wr(`HCOR_OFF_MOTOR_RESET, 16'h0001);
    idle(10);
    plc_u.wr(`HCOR_OFF_MOTOR_RESET, 16'h0000);
    idle(30);
    chk("short hold", 16'({n_mr[3:0], fault_left, fault_right}), 16'h0003);
    plc_u.wr(`HCOR_OFF_MOTOR_RESET, 16'h0001);
    for (int k = 0; k < 60 && n_mr == 0; k++) idle(1);
    if (n_mr == 0) chk("reset wait", 16'h0000, 16'h0001);
    idle(30);
    chk("held reset", 16'({n_mr[3:0], fault_left, fault_right}), 16'h0004);
    $display("test motor reset done");
    results();
  end
endmodule // tb
`default_nettype wire

// ==== src/hcor_defines.vh ====
// register offsets, field positions and timing counts for the host command registers
`ifndef HCOR_DEFINES_VH
`define HCOR_DEFINES_VH
`define HCOR_ADDR_W            8
`define HCOR_DATA_W            16
`define HCOR_OFF_STOP_CMD      8'h14
`define HCOR_OFF_MOTOR_RESET   8'h16
`define HCOR_OFF_AUX_CTRL      8'h3F
`define HCOR_OFF_UP_JAM        8'h6D
`define HCOR_OFF_FWD_W1        8'h8B
`define HCOR_OFF_FWD_W2        8'h8C
`define HCOR_OFF_DN_JAM        8'hBD
`define HCOR_OFF_REV_W1        8'hED
`define HCOR_OFF_REV_W2        8'hEE
`define HCOR_AUX_L_DIR_BIT     8
`define HCOR_AUX_R_DIR_BIT     9
`define HCOR_AUX_L_LVL_BIT     12
`define HCOR_AUX_R_LVL_BIT     13
`define HCOR_AUX_MASK          16'h3300
`define HCOR_STOP_NONE         16'h0000
`define HCOR_STOP_SET          16'h0001
`define HCOR_STOP_CLEAR        16'h0002
`define HCOR_RESET_HOLD_MS     500
`define HCOR_CLK_HZ            50000000
`define HCOR_RESET_HOLD_CYC    ((`HCOR_CLK_HZ / 1000) * `HCOR_RESET_HOLD_MS)
`endif

// ==== src/hcor_host_command_output_registers.v ====
// host command register bank of a conveyor zone controller
// How it works
// - reverse induct tracking words 1 and 2 are stored and presented separately.
// - motor reset register value 1 asserts the reset command, 0 withdraws it.
// - fatal motor faults latch until a recognised reset clears left and right.
// - bits 8 and 9 pick input or output for left and right auxiliary pins.
// - bits 12 and 13 set output levels, effective only while direction selects output.
// - other auxiliary bits are reserved, written zero by host, ignored here.
// - host pin control is ignored unless the pin usage is configured none.
// - stop word 0 nothing, 1 enters stopped state, 2 clears it.
// - a zero-to-one write to upstream jam clear pulses one upstream clear cycle.
// - a zero-to-one write to downstream jam clear pulses one downstream clear cycle.
// - holding one never retries; each attempt needs a fresh rising change.
`default_nettype none
`include "hcor_defines.vh"
module hcor_host_command_output_registers #(
  parameter integer RESET_HOLD_CYC = `HCOR_RESET_HOLD_CYC
) (
  input  wire                      clk_sys,
  input  wire                      rst,
  input  wire                      wr_en,
  input  wire                      rd_en,
  input  wire [`HCOR_ADDR_W-1:0]   addr,
  input  wire [`HCOR_DATA_W-1:0]   wr_data,
  output reg  [`HCOR_DATA_W-1:0]   rd_data,
  output reg                       rd_valid,
  input  wire                      aux_left_usage_none,
  input  wire                      aux_right_usage_none,
  input  wire                      aux_left_in,
  input  wire                      aux_right_in,
  output reg                       aux_left_out,
  output reg                       aux_left_oe,
  output reg                       aux_right_out,
  output reg                       aux_right_oe,
  output reg  [`HCOR_DATA_W-1:0]   induct_fwd_word1,
  output reg  [`HCOR_DATA_W-1:0]   induct_fwd_word2,
  output reg  [`HCOR_DATA_W-1:0]   induct_rev_word1,
  output reg  [`HCOR_DATA_W-1:0]   induct_rev_word2,
  input  wire                      fault_left_set,
  input  wire                      fault_right_set,
  output reg                       fault_left,
  output reg                       fault_right,
  output reg                       motor_reset_pulse,
  output reg                       stop_group_stopped,
  output reg                       upstream_jam_clear_pulse,
  output reg                       downstream_jam_clear_pulse
);
  reg  [`HCOR_DATA_W-1:0] stop_group_command;
  reg  [`HCOR_DATA_W-1:0] motor_fault_reset;
  reg  [`HCOR_DATA_W-1:0] aux_pin_output_control;
  reg  [`HCOR_DATA_W-1:0] upstream_jam_clear;
  reg  [`HCOR_DATA_W-1:0] downstream_jam_clear;
  reg  [31:0]             hold_cnt;
  reg                     hold_done;
  reg  [1:0]              aux_l_sync;
  reg  [1:0]              aux_r_sync;
  reg  [`HCOR_DATA_W-1:0] next_rd_data;

  function is_rise;
    input [`HCOR_DATA_W-1:0] prev_val;
    input [`HCOR_DATA_W-1:0] new_val;
    begin
      is_rise = (prev_val == 16'h0000) && (new_val != 16'h0000);
    end
  endfunction

  wire wr_stop = wr_en && (addr == `HCOR_OFF_STOP_CMD);
  wire wr_up   = wr_en && (addr == `HCOR_OFF_UP_JAM);
  wire wr_dn   = wr_en && (addr == `HCOR_OFF_DN_JAM);
  wire reset_held = motor_fault_reset[0];

  // register writes; reserved aux bits are dropped on the way in
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stop_group_command     <= 16'h0000;
      motor_fault_reset      <= 16'h0000;
      aux_pin_output_control <= 16'h0000;
      upstream_jam_clear     <= 16'h0000;
      downstream_jam_clear   <= 16'h0000;
      induct_fwd_word1       <= 16'h0000;
      induct_fwd_word2       <= 16'h0000;
      induct_rev_word1       <= 16'h0000;
      induct_rev_word2       <= 16'h0000;
    end else if (wr_en) begin
      case (addr)
        `HCOR_OFF_STOP_CMD:    stop_group_command <= wr_data;
        `HCOR_OFF_MOTOR_RESET: motor_fault_reset <= wr_data;
        `HCOR_OFF_AUX_CTRL:    aux_pin_output_control <= wr_data & `HCOR_AUX_MASK;
        `HCOR_OFF_UP_JAM:      upstream_jam_clear <= wr_data;
        `HCOR_OFF_DN_JAM:      downstream_jam_clear <= wr_data;
        `HCOR_OFF_FWD_W1:      induct_fwd_word1 <= wr_data;
        `HCOR_OFF_FWD_W2:      induct_fwd_word2 <= wr_data;
        `HCOR_OFF_REV_W1:      induct_rev_word1 <= wr_data;
        `HCOR_OFF_REV_W2:      induct_rev_word2 <= wr_data;
        default: begin
        end
      endcase
    end
  end

  // one pulse per rising write; a held one never retriggers
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      upstream_jam_clear_pulse   <= 1'b0;
      downstream_jam_clear_pulse <= 1'b0;
    end else begin
      upstream_jam_clear_pulse   <= wr_up && is_rise(upstream_jam_clear, wr_data);
      downstream_jam_clear_pulse <= wr_dn && is_rise(downstream_jam_clear, wr_data);
    end
  end

  // reset recognised only after an unbroken hold; one pulse per hold
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hold_cnt          <= 32'h00000000;
      hold_done         <= 1'b0;
      motor_reset_pulse <= 1'b0;
    end else begin
      motor_reset_pulse <= 1'b0;
      if (!reset_held) begin
        hold_cnt  <= 32'h00000000;
        hold_done <= 1'b0;
      end else if (!hold_done) begin
        if (hold_cnt >= RESET_HOLD_CYC - 1) begin
          hold_done         <= 1'b1;
          motor_reset_pulse <= 1'b1;
        end else begin
          hold_cnt <= hold_cnt + 32'h00000001;
        end
      end
    end
  end

  // a new fault in the clearing cycle wins over the clear
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fault_left  <= 1'b0;
      fault_right <= 1'b0;
    end else begin
      if (fault_left_set)
        fault_left <= 1'b1;
      else if (motor_reset_pulse)
        fault_left <= 1'b0;
      if (fault_right_set)
        fault_right <= 1'b1;
      else if (motor_reset_pulse)
        fault_right <= 1'b0;
    end
  end

  // stop group; other codes leave the state alone
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stop_group_stopped <= 1'b0;
    end else if (wr_stop) begin
      if (wr_data == `HCOR_STOP_SET)
        stop_group_stopped <= 1'b1;
      else if (wr_data == `HCOR_STOP_CLEAR)
        stop_group_stopped <= 1'b0;
    end
  end

  // aux pins; usage straps are static configuration, pin inputs synchronised
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      aux_left_out  <= 1'b0;
      aux_left_oe   <= 1'b0;
      aux_right_out <= 1'b0;
      aux_right_oe  <= 1'b0;
      aux_l_sync    <= 2'b00;
      aux_r_sync    <= 2'b00;
    end else begin
      aux_l_sync    <= {aux_l_sync[0], aux_left_in};
      aux_r_sync    <= {aux_r_sync[0], aux_right_in};
      aux_left_oe   <= aux_left_usage_none &&
                       aux_pin_output_control[`HCOR_AUX_L_DIR_BIT];
      aux_right_oe  <= aux_right_usage_none &&
                       aux_pin_output_control[`HCOR_AUX_R_DIR_BIT];
      aux_left_out  <= aux_left_usage_none &&
                       aux_pin_output_control[`HCOR_AUX_L_DIR_BIT] &&
                       aux_pin_output_control[`HCOR_AUX_L_LVL_BIT];
      aux_right_out <= aux_right_usage_none &&
                       aux_pin_output_control[`HCOR_AUX_R_DIR_BIT] &&
                       aux_pin_output_control[`HCOR_AUX_R_LVL_BIT];
    end
  end

  // readback; aux reads show input levels in the low bits
  always @* begin
    next_rd_data = 16'h0000;
    case (addr)
      `HCOR_OFF_STOP_CMD:    next_rd_data = stop_group_command;
      `HCOR_OFF_MOTOR_RESET: next_rd_data = motor_fault_reset;
      `HCOR_OFF_AUX_CTRL:    next_rd_data = aux_pin_output_control |
                                            {14'h0000, aux_r_sync[1], aux_l_sync[1]};
      `HCOR_OFF_UP_JAM:      next_rd_data = upstream_jam_clear;
      `HCOR_OFF_DN_JAM:      next_rd_data = downstream_jam_clear;
      `HCOR_OFF_FWD_W1:      next_rd_data = induct_fwd_word1;
      `HCOR_OFF_FWD_W2:      next_rd_data = induct_fwd_word2;
      `HCOR_OFF_REV_W1:      next_rd_data = induct_rev_word1;
      `HCOR_OFF_REV_W2:      next_rd_data = induct_rev_word2;
      default:               next_rd_data = 16'h0000;
    endcase
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_data  <= 16'h0000;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_en;
      if (rd_en)
        rd_data <= next_rd_data;
    end
  end
endmodule // hcor_host_command_output_registers
`default_nettype wire
